/* logic/secdis_drive.sv */
// Drive end: decodes disable-password, erase-prepare and erase-unit commands.
// Assumes the host keeps the task-file order; passwords come from outside.
//
// Contract
// - F6h decodes as password security disable
// - Disable requests exactly one data-out sector
// - Matching password turns lock function off
// - Disable never alters stored master password
// - Security off with user selector aborts
// - Word 0 bit 0 selector, words 1-16 password
// - Selector zero user, one master password
// - Host issues disable only while unlocked
// - F3h decodes as erase preparation
// - Prepare directly precedes erase unit
// - Prepare directly precedes format unit (no format unit command is decoded here)
// - Prepare moves no data
// - Erase unit without prior prepare aborts
`timescale 1ns/1ns
`default_nettype none
module secdis_drive
  import secdis_pkg::*;
#(
  parameter int SECTOR_WORDS = SECDIS_SECTOR_WORDS
)
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  secdis_if.drive           link,
  input  wire logic [255:0] user_pw,
  input  wire logic [255:0] master_pw,
  input  wire logic         security_enabled,
  output logic              lock_off_pulse,
  output logic              erase_start,
  output logic              erase_armed
);
  typedef enum logic [3:0] {
    SECDIS_IDLE = 4'b0001,
    SECDIS_XFER = 4'b0010,
    SECDIS_EVAL = 4'b0100,
    SECDIS_DONE = 4'b1000
  } secdis_state_t;

  secdis_state_t state;
  logic [8:0]    word_idx;
  logic          sel_master;
  logic          match_user;
  logic          match_master;
  logic          abort;
  logic          take_cmd;
  logic          take_word;
  logic          last_word;
  logic          is_disable;
  logic          is_prepare;
  logic          is_erase;

  // Word counter is nine bits; the password has to fit inside the sector
  localparam logic [8:0] LAST_WORD = 9'(SECTOR_WORDS - 1);
  if (SECTOR_WORDS <= SECDIS_PW_LAST || SECTOR_WORDS > 512) begin : g_bad_sector
    $error("secdis_drive: SECTOR_WORDS out of range");
  end

  // Stored keys are 256 bits wide, so the password spans sixteen words
  if (SECDIS_PW_LAST - SECDIS_PW_FIRST + 1 != 16) begin : g_bad_span
    $error("secdis_drive: password span must be sixteen words");
  end

  function automatic logic [7:0] secdis_status(input logic busy, input logic drq,
                                               input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[SECDIS_ST_BSY] = busy;
    s[SECDIS_ST_RDY] = 1'b1;
    s[SECDIS_ST_DSC] = 1'b1;
    s[SECDIS_ST_DRQ] = drq;
    s[SECDIS_ST_ERR] = err;
    return s;
  endfunction : secdis_status

  assign take_cmd  = link.cmd_valid && (state == SECDIS_IDLE);
  assign take_word = link.data_valid && (state == SECDIS_XFER);
  assign last_word = take_word && (word_idx == LAST_WORD);
  // Decoded once, so every compare sees the same taken command
  assign is_disable = take_cmd && (link.cmd_code == SECDIS_CMD_DISABLE);
  assign is_prepare = take_cmd && (link.cmd_code == SECDIS_CMD_PREPARE);
  assign is_erase   = take_cmd && (link.cmd_code == SECDIS_CMD_ERASE);

  // Only disable has a data phase; every other command finishes at once
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= SECDIS_IDLE;
    end else begin
      case (state)
        SECDIS_IDLE: begin
          if (is_disable)
            state <= SECDIS_XFER;
          else if (take_cmd)
            state <= SECDIS_DONE;
        end
        SECDIS_XFER: begin
          if (last_word)
            state <= SECDIS_EVAL;
        end
        SECDIS_EVAL: state <= SECDIS_DONE;
        SECDIS_DONE: state <= SECDIS_IDLE;
        default:     state <= SECDIS_IDLE;
      endcase
    end
  end

  // Word 0 carries the selector; its reserved bits are ignored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      word_idx   <= 9'd0;
      sel_master <= 1'b0;
    end else if (take_cmd) begin
      word_idx <= 9'd0;
    end else if (take_word) begin
      if (word_idx == 9'd0)
        sel_master <= link.data_word[SECDIS_SEL_BIT];
      word_idx <= word_idx + 9'd1;
    end
  end

  // Compared word by word, so no sector buffer is needed
  secdis_pw_cmp u_cmp (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .clear        (take_cmd),
    .word_valid   (take_word),
    .word_idx     (word_idx),
    .word         (link.data_word),
    .user_pw      (user_pw),
    .master_pw    (master_pw),
    .match_user   (match_user),
    .match_master (match_master)
  );

  // Outcome decided at EVAL for disable, at command take for others
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      abort          <= 1'b0;
      lock_off_pulse <= 1'b0;
      erase_start    <= 1'b0;
    end else begin
      lock_off_pulse <= 1'b0;
      erase_start    <= 1'b0;
      if (take_cmd) begin
        abort <= 1'b0;
        if (is_erase) begin
          abort       <= !erase_armed;
          erase_start <= erase_armed;
        end
      end else if (state == SECDIS_EVAL) begin
        if (!security_enabled && !sel_master)
          abort <= 1'b1;
        else if (sel_master ? match_master : match_user)
          lock_off_pulse <= 1'b1;
        else
          abort <= 1'b1;
      end
    end
  end

  // Any command other than prepare disarms; prepare itself arms with no data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      erase_armed <= 1'b0;
    else if (take_cmd)
      erase_armed <= is_prepare;
  end

  // Task-file flags stand until the next command is taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link.done                 <= 1'b0;
      link.command_error_flags  <= SECDIS_ERR_RESET;
      link.command_status_flags <= SECDIS_STATUS_RESET;
    end else begin
      link.done <= (state == SECDIS_DONE);
      case (state)
        SECDIS_IDLE: begin
          if (take_cmd) begin
            link.command_status_flags <= secdis_status(1'b1, 1'b0, 1'b0);
            link.command_error_flags  <= SECDIS_ERR_RESET;
          end
        end
        SECDIS_XFER: begin
          // Busy rises with the last word, so no idle gap shows during EVAL
          if (last_word)
            link.command_status_flags <= secdis_status(1'b1, 1'b0, 1'b0);
          else
            link.command_status_flags <= secdis_status(1'b0, 1'b1, 1'b0);
        end
        SECDIS_EVAL: link.command_status_flags <= secdis_status(1'b1, 1'b0, 1'b0);
        SECDIS_DONE: begin
          link.command_status_flags <= secdis_status(1'b0, 1'b0, abort);
          link.command_error_flags[SECDIS_ERR_ABT] <= abort;
        end
        default: link.command_status_flags <= SECDIS_STATUS_RESET;
      endcase
    end
  end

  // Level from state; it falls on the edge that takes the last word
  assign link.data_req = (state == SECDIS_XFER);
endmodule : secdis_drive
`default_nettype wire

/* logic/secdis_host.sv */
// Host end: software issues commands and sector words through a register port.
// Assumes software writes 256 words after a disable command, in order.
`timescale 1ns/1ns
`default_nettype none
module secdis_host
  import secdis_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  secdis_if.host           link,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata
);
  logic busy;
  logic done_seen;

  // Commands are only sent when idle; software orders prepare before erase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link.cmd_valid  <= 1'b0;
      link.cmd_code   <= 8'h00;
      link.data_valid <= 1'b0;
      link.data_word  <= 16'h0000;
    end else begin
      link.cmd_valid  <= wr && addr == SECDIS_REG_CMD && !busy;
      link.data_valid <= wr && addr == SECDIS_REG_WDATA && link.data_req;
      if (wr && addr == SECDIS_REG_CMD)
        link.cmd_code <= wdata[7:0];
      if (wr && addr == SECDIS_REG_WDATA)
        link.data_word <= wdata;
    end
  end

  // Set wins over clear for the completion flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy      <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      if (link.done)
        busy <= 1'b0;
      else if (link.cmd_valid)
        busy <= 1'b1;
      if (link.done)
        done_seen <= 1'b1;
      else if (wr && addr == SECDIS_REG_CTRL && wdata[0])
        done_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      rdata <= 16'h0000;
    else if (rd) begin
      case (addr)
        SECDIS_REG_STAT:  rdata <= {13'h0000, link.data_req, done_seen, busy};
        SECDIS_REG_DSTAT: rdata <= {8'h00, link.command_status_flags};
        SECDIS_REG_DERR:  rdata <= {8'h00, link.command_error_flags};
        default:          rdata <= 16'h0000;
      endcase
    end else
      rdata <= 16'h0000;
  end
endmodule : secdis_host
`default_nettype wire

/* logic/secdis_if.sv */
// Task-file link between host end and drive end.
// Assumes both ends on clk_sys; no tri-state pins.
`timescale 1ns/1ns
`default_nettype none
interface secdis_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        data_valid;
  logic [15:0] data_word;
  logic        data_req;
  logic        done;
  logic [7:0]  command_error_flags;
  logic [7:0]  command_status_flags;
  modport drive (input cmd_valid, cmd_code, data_valid, data_word,
                 output data_req, done, command_error_flags, command_status_flags);
  modport host  (output cmd_valid, cmd_code, data_valid, data_word,
                 input data_req, done, command_error_flags, command_status_flags);
endinterface : secdis_if
`default_nettype wire

/* logic/secdis_pkg.sv */
// Shared constants for the security disable / erase prepare command path.
// Assumes a single 100 MHz clock shared by host and drive ends.
package secdis_pkg;
  localparam logic [7:0] SECDIS_CMD_DISABLE  = 8'hf6;
  localparam logic [7:0] SECDIS_CMD_PREPARE  = 8'hf3;
  localparam logic [7:0] SECDIS_CMD_ERASE    = 8'hf4;
  localparam int         SECDIS_SECTOR_WORDS = 256;
  localparam int         SECDIS_PW_FIRST     = 1;
  localparam int         SECDIS_PW_LAST      = 16;
  localparam int         SECDIS_SEL_BIT      = 0;
  // Error register field positions
  localparam int         SECDIS_ERR_ABT      = 2;
  // Status register field positions
  localparam int         SECDIS_ST_BSY       = 7;
  localparam int         SECDIS_ST_RDY       = 6;
  localparam int         SECDIS_ST_DSC       = 4;
  localparam int         SECDIS_ST_DRQ       = 3;
  localparam int         SECDIS_ST_ERR       = 0;
  localparam logic [7:0] SECDIS_ERR_RESET    = 8'h00;
  localparam logic [7:0] SECDIS_STATUS_RESET = 8'h50;
  // Host register map offsets
  localparam logic [3:0] SECDIS_REG_CTRL     = 4'h0;
  localparam logic [3:0] SECDIS_REG_CMD      = 4'h1;
  localparam logic [3:0] SECDIS_REG_WDATA    = 4'h2;
  localparam logic [3:0] SECDIS_REG_STAT     = 4'h3;
  localparam logic [3:0] SECDIS_REG_ERR      = 4'h4;
  localparam logic [3:0] SECDIS_REG_DSTAT    = 4'h5;
  localparam logic [3:0] SECDIS_REG_DERR     = 4'h6;
endpackage : secdis_pkg

/* logic/secdis_pw_cmp.sv */
// Accumulates password words and compares them against two stored keys.
// Assumes words arrive in order, index 1..16, with clear before each sector.
`timescale 1ns/1ns
`default_nettype none
module secdis_pw_cmp
  import secdis_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         clear,
  input  wire logic         word_valid,
  input  wire logic [8:0]   word_idx,
  input  wire logic [15:0]  word,
  input  wire logic [255:0] user_pw,
  input  wire logic [255:0] master_pw,
  output logic              match_user,
  output logic              match_master
);
  logic diff_user;
  logic diff_master;
  logic in_pw;

  assign in_pw = (word_idx >= 9'(SECDIS_PW_FIRST)) && (word_idx <= 9'(SECDIS_PW_LAST));

  // Running mismatch flags avoid storing the whole 32-byte password
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      diff_user   <= 1'b0;
      diff_master <= 1'b0;
    end else if (clear) begin
      diff_user   <= 1'b0;
      diff_master <= 1'b0;
    end else if (word_valid && in_pw) begin
      if (word != user_pw[16*(word_idx-9'd1) +: 16])
        diff_user <= 1'b1;
      if (word != master_pw[16*(word_idx-9'd1) +: 16])
        diff_master <= 1'b1;
    end
  end

  assign match_user   = !diff_user;
  assign match_master = !diff_master;
endmodule : secdis_pw_cmp
`default_nettype wire

/* verif/secdis_asserts.sv */
// Checker: link timing of the disable, prepare and erase unit commands.
// Assumes link signals wired in directly; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module secdis_asserts
  import secdis_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       data_valid,
  input wire logic       data_req,
  input wire logic       done,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] command_status_flags
);
  logic       take;
  logic [8:0] wcnt;
  logic [7:0] last_code;
  // Taken only when idle; drive ignores it otherwise
  assign take = cmd_valid && !command_status_flags[SECDIS_ST_BSY] && !data_req;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wcnt <= 9'h000;
    end else if (take) begin
      wcnt <= 9'h000;
    end else if (data_valid && data_req) begin
      wcnt <= wcnt + 9'h001;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_code <= 8'h00;
    end else if (take) begin
      last_code <= cmd_code;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_prep_quiet;
    take && cmd_code == SECDIS_CMD_PREPARE |=> !data_req ##1 (done && !data_req);
  endproperty
  a_prep_quiet: assert property (p_prep_quiet) else $error("prepare moved data");
  property p_prep_clean;
    take && cmd_code == SECDIS_CMD_PREPARE |-> ##2 !command_error_flags[SECDIS_ERR_ABT];
  endproperty
  a_prep_clean: assert property (p_prep_clean) else $error("prepare aborted");
  property p_dis_req;
    take && cmd_code == SECDIS_CMD_DISABLE |-> ##2 data_req;
  endproperty
  a_dis_req: assert property (p_dis_req) else $error("no sector request");
  property p_one_sector;
    data_req |-> wcnt < 9'h100;
  endproperty
  a_one_sector: assert property (p_one_sector) else $error("sector too long");
  property p_eval_done;
    data_valid && data_req && wcnt == 9'h0ff |-> ##[1:3] done;
  endproperty
  a_eval_done: assert property (p_eval_done) else $error("no end after sector");
  property p_erase_unarmed;
    take && cmd_code == SECDIS_CMD_ERASE && last_code != SECDIS_CMD_PREPARE
      |-> ##2 done && command_error_flags[SECDIS_ERR_ABT];
  endproperty
  a_erase_unarmed: assert property (p_erase_unarmed) else $error("erase not aborted");
  property p_erase_armed;
    take && cmd_code == SECDIS_CMD_ERASE && last_code == SECDIS_CMD_PREPARE
      |-> ##2 done && !command_error_flags[SECDIS_ERR_ABT];
  endproperty
  a_erase_armed: assert property (p_erase_armed) else $error("armed erase aborted");
  property p_abort_flags;
    done && command_error_flags[SECDIS_ERR_ABT]
      |-> command_status_flags[SECDIS_ST_ERR] && !command_status_flags[SECDIS_ST_BSY];
  endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("abort status wrong");
endmodule : secdis_asserts
`default_nettype wire

/* verif/secdis_bench.sv */
// Bench: host end and drive end joined by the link, software port driven here.
// Assumes 100 MHz clk_sys and the package register map.
`timescale 1ns/1ns
`default_nettype none
module secdis_bench
  import secdis_pkg::*;
;
  logic         clk_sys, rstn, wr, rd, sec_en, lock_off, erase_go, armed;
  logic [3:0]   addr;
  logic [15:0]  wdata, rdata, got;
  logic [255:0] upw, mpw;
  int           error_cnt, check_count, lock_cnt, erase_cnt, done_cnt;
  secdis_if link_if ();
  secdis_host u_secdis_host (.clk_sys(clk_sys), .rstn(rstn), .link(link_if), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  secdis_drive u_secdis_drive (.clk_sys(clk_sys), .rstn(rstn), .link(link_if), .user_pw(upw),
    .master_pw(mpw), .security_enabled(sec_en), .lock_off_pulse(lock_off),
    .erase_start(erase_go), .erase_armed(armed));
  secdis_asserts u_secdis_asserts (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_valid(link_if.cmd_valid), .cmd_code(link_if.cmd_code),
    .data_valid(link_if.data_valid), .data_req(link_if.data_req), .done(link_if.done),
    .command_error_flags(link_if.command_error_flags),
    .command_status_flags(link_if.command_status_flags));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Counters, since pulses last one cycle only
  always @(posedge clk_sys) begin
    lock_cnt <= lock_cnt + int'(lock_off === 1'b1);
    erase_cnt <= erase_cnt + int'(erase_go === 1'b1);
    done_cnt <= done_cnt + int'(link_if.done === 1'b1);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Full command: words 17..255 carry junk that must be ignored
  task automatic run(input logic [7:0] code, input logic sel, input logic [15:0] pwb,
                     input logic ab, input int lk, input int er);
    int d0, l0, e0;
    d0 = done_cnt;
    l0 = lock_cnt;
    e0 = erase_cnt;
    wr_reg(SECDIS_REG_CMD, {8'h00, code});
    if (code == SECDIS_CMD_DISABLE) begin
      rd_reg(SECDIS_REG_STAT, got);
      chk(got, 16'h0005);
      for (int i = 0; i < SECDIS_SECTOR_WORDS; i++)
        wr_reg(SECDIS_REG_WDATA, i == 0 ? {15'h7fff, sel} :
               (i <= SECDIS_PW_LAST ? pwb + i[15:0] : 16'hffff));
    end
    for (int n = 0; n < 40 && done_cnt == d0; n++) @(posedge clk_sys);
    #1;
    chk(16'(done_cnt - d0), 16'h0001);
    chk(16'(lock_cnt - l0), 16'(lk));
    chk(16'(erase_cnt - e0), 16'(er));
    rd_reg(SECDIS_REG_STAT, got);
    chk(got, 16'h0002);
    rd_reg(SECDIS_REG_DERR, got);
    chk(got, ab ? 16'h0004 : 16'h0000);
    rd_reg(SECDIS_REG_DSTAT, got);
    chk(got, ab ? 16'h0051 : 16'h0050);
    wr_reg(SECDIS_REG_CTRL, 16'h0001);
    $display("test %h sel %0d ended", code, sel);
  endtask : run
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {rstn, wr, rd, addr, wdata} = '0;
    {error_cnt, check_count} = '0;
    sec_en = 1'b1;
    for (int k = 0; k < 16; k++) begin
      upw[16*k +: 16] = 16'h1101 + k[15:0];
      mpw[16*k +: 16] = 16'h2201 + k[15:0];
    end
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(SECDIS_REG_DSTAT, got);
    chk(got, 16'h0050);
    rd_reg(4'hf, got);
    chk(got, 16'h0000);
    run(SECDIS_CMD_PREPARE, 1'b0, 16'h0, 1'b0, 0, 0);
    chk({15'h0, armed}, 16'h0001);
    run(SECDIS_CMD_ERASE, 1'b0, 16'h0, 1'b0, 0, 1);
    run(SECDIS_CMD_ERASE, 1'b0, 16'h0, 1'b1, 0, 0);
    run(SECDIS_CMD_DISABLE, 1'b0, 16'h1100, 1'b0, 1, 0);
    run(SECDIS_CMD_DISABLE, 1'b1, 16'h2200, 1'b0, 1, 0);
    run(SECDIS_CMD_DISABLE, 1'b1, 16'h1100, 1'b1, 0, 0);
    run(SECDIS_CMD_PREPARE, 1'b0, 16'h0, 1'b0, 0, 0);
    run(SECDIS_CMD_DISABLE, 1'b0, 16'h3300, 1'b1, 0, 0);
    chk({15'h0, armed}, 16'h0000);
    run(SECDIS_CMD_ERASE, 1'b0, 16'h0, 1'b1, 0, 0);
    run(SECDIS_CMD_PREPARE, 1'b0, 16'h0, 1'b0, 0, 0);
    run(8'h00, 1'b0, 16'h0, 1'b0, 0, 0);
    chk({15'h0, armed}, 16'h0000);
    run(SECDIS_CMD_ERASE, 1'b0, 16'h0, 1'b1, 0, 0);
    sec_en <= 1'b0;
    run(SECDIS_CMD_DISABLE, 1'b0, 16'h1100, 1'b1, 0, 0);
    run(SECDIS_CMD_DISABLE, 1'b1, 16'h2200, 1'b0, 1, 0);
    finish_test();
  end
endmodule : secdis_bench
`default_nettype wire
